// >>> hw/sled_map.svh
/*
 * Constants of the status LED block: register offsets, field positions,
 * reset values and blink timing.
 * Assumes a 50 MHz mclk and a word-aligned Avalon-MM byte address.
 */
`ifndef SLED_MAP_SVH
`define SLED_MAP_SVH

////////////////////////////////////////////////////////////////////////////////
// clock and blink timing
`define SLED_CLK_HZ        50000000
`define SLED_TICK_MS       50
`define SLED_TICK_CYCLES   (`SLED_TICK_MS * (`SLED_CLK_HZ / 1000))
`define SLED_TICKS_PER_S   (1000 / `SLED_TICK_MS)
`define SLED_FLICK_HZ      10
`define SLED_FLICK_FLASHES 10
`define SLED_RECOV_HZ      2
`define SLED_PULSE_HZ      1
`define SLED_GAP_MS        1000
`define SLED_NET_TAIL_MS   2000
`define SLED_RECOV_HALF    (`SLED_TICKS_PER_S / (2 * `SLED_RECOV_HZ))
`define SLED_PULSE_HALF    (`SLED_TICKS_PER_S / (2 * `SLED_PULSE_HZ))
`define SLED_FLICK_TICKS   (`SLED_FLICK_FLASHES * `SLED_TICKS_PER_S / `SLED_FLICK_HZ)
`define SLED_GAP_TICKS     (`SLED_GAP_MS / `SLED_TICK_MS)
`define SLED_NET_TAIL      (`SLED_NET_TAIL_MS / `SLED_TICK_MS)

////////////////////////////////////////////////////////////////////////////////
// register offsets (byte addresses)
`define SLED_IO_CTRL_OFS   4'h0
`define SLED_NET_CTRL_OFS  4'h4
`define SLED_STATUS_OFS    4'h8
`define SLED_IO_CTRL_RST   32'h0000_0000
`define SLED_NET_CTRL_RST  32'h0000_0000

// io control fields
`define SLED_IO_LIB        0
`define SLED_IO_STARTUP    1
`define SLED_IO_HW_FAULT   2
`define SLED_IO_RECOV      3
`define SLED_IO_BUS_ERR    4
`define SLED_IO_CODE_LSB   8
`define SLED_IO_ARG_LSB    16

// network control fields and codes
`define SLED_NET_TYPE_LSB  0
`define SLED_NET_FAULT_LSB 4
`define SLED_NET_LEVEL_LSB 8
`define SLED_NT_NONE       2'h0
`define SLED_NT_2G         2'h1
`define SLED_NT_3G         2'h2
`define SLED_NF_NONE       3'h0
`define SLED_NF_SIM_ABSENT 3'h1
`define SLED_NF_SIM_LOCKED 3'h2
`define SLED_NF_MODEM_GONE 3'h3
`define SLED_NF_MODEM_INIT 3'h4
`define SLED_NF_MODEM_TMO  3'h5

`endif

// >>> hw/sled_pkg.sv
/*
 * Types of the status LED block.
 * Assumes nothing beyond the map header for its users.
 */
package sled_pkg;
    typedef struct packed {
        logic red;
        logic green;
    } sled_rg_s;

    typedef struct packed {
        logic yellow;
        logic green;
    } sled_bar_s;

    typedef sled_bar_s [4:0] sled_bar_t;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'h0,
        SEQ_FLICK = 3'h1,
        SEQ_GAP_A = 3'h2,
        SEQ_DIG_A = 3'h3,
        SEQ_GAP_B = 3'h4,
        SEQ_DIG_B = 3'h5,
        SEQ_TAIL  = 3'h6
    } sled_seq_e;
endpackage

// >>> hw/sled_pulse_seq.sv
/*
 * Pulse group sequencer: optional flicker, group A pulses, pause,
 * group B pulses, tail pause, repeat while run is high.
 * Assumes tick is a one-cycle enable every 50 ms.
 */
`include "sled_map.svh"

module sled_pulse_seq (
    input  wire logic       mclk,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic       run,
    input  wire logic       flick_en,
    input  wire logic [5:0] count_a,
    input  wire logic [5:0] count_b,
    input  wire logic [5:0] tail_gap,
    output logic            led_q,
    output logic            busy_q
);
    import sled_pkg::*;

    sled_seq_e  st_q, st_d;
    logic [5:0] tmr_q, tmr_d, n_q, n_d;
    logic       led_d;

    wire logic [5:0] grp_cnt  = (st_q == SEQ_DIG_B) ? count_b : count_a;
    wire logic       win_end  = tmr_q == 6'(2 * `SLED_PULSE_HALF - 1);
    wire logic       grp_done = (n_q + 6'h01) >= grp_cnt;
    wire logic       gap_end  = tmr_q == 6'(`SLED_GAP_TICKS - 1);
    wire logic       tail_end = tmr_q == (tail_gap - 6'h01);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d  = st_q;
        tmr_d = tmr_q;
        n_d   = n_q;
        led_d = led_q;
        if (!run) begin
            st_d  = SEQ_IDLE;
            tmr_d = 6'h00;
            n_d   = 6'h00;
            led_d = 1'b0;
        end else if (st_q == SEQ_IDLE) begin
            st_d  = flick_en ? SEQ_FLICK : SEQ_DIG_A;
            tmr_d = 6'h00;
            n_d   = 6'h00;
            led_d = flick_en | (count_a != 6'h00);
        end else if (tick) begin
            tmr_d = tmr_q + 6'h01;
            unique case (st_q)
                SEQ_FLICK: begin
                    // tick is the flicker half period
                    led_d = ~led_q;
                    if (tmr_q == 6'(`SLED_FLICK_TICKS - 1)) begin
                        st_d  = SEQ_GAP_A;
                        tmr_d = 6'h00;
                        led_d = 1'b0;
                    end
                end
                SEQ_GAP_A, SEQ_GAP_B: begin
                    led_d = 1'b0;
                    if (gap_end) begin
                        st_d  = (st_q == SEQ_GAP_A) ? SEQ_DIG_A : SEQ_DIG_B;
                        tmr_d = 6'h00;
                        n_d   = 6'h00;
                        led_d = (st_q == SEQ_GAP_A) ? (count_a != 6'h00)
                                                    : (count_b != 6'h00);
                    end
                end
                SEQ_DIG_A, SEQ_DIG_B: begin
                    // an empty group still takes one dark window
                    led_d = (tmr_d < 6'(`SLED_PULSE_HALF)) && (grp_cnt != 6'h00);
                    if (win_end) begin
                        tmr_d = 6'h00;
                        n_d   = n_q + 6'h01;
                        // next window opens lit, so every pulse gets its full on time
                        led_d = grp_cnt != 6'h00;
                        if (grp_done) begin
                            st_d  = (st_q == SEQ_DIG_A) ? SEQ_GAP_B : SEQ_TAIL;
                            led_d = 1'b0;
                        end
                    end
                end
                SEQ_TAIL: begin
                    led_d = 1'b0;
                    if (tail_end) begin
                        st_d  = flick_en ? SEQ_FLICK : SEQ_DIG_A;
                        tmr_d = 6'h00;
                        n_d   = 6'h00;
                        led_d = flick_en | (count_a != 6'h00);
                    end
                end
                default: begin
                    st_d  = SEQ_IDLE;
                    led_d = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            st_q   <= SEQ_IDLE;
            tmr_q  <= 6'h00;
            n_q    <= 6'h00;
            led_q  <= 1'b0;
            busy_q <= 1'b0;
        end else begin
            st_q   <= st_d;
            tmr_q  <= tmr_d;
            n_q    <= n_d;
            led_q  <= led_d;
            busy_q <= st_d != SEQ_IDLE;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence tail_done_s;
        st_q == SEQ_TAIL && tick && run && tail_end && flick_en;
    endsequence

    flick_start_a: assert property (
        run && st_q == SEQ_IDLE && flick_en |=> st_q == SEQ_FLICK && led_q)
        else $error("flicker did not open the sequence");
    flick_toggle_a: assert property (
        run && tick && st_q == SEQ_FLICK && !(st_d == SEQ_GAP_A) |=> led_q != $past(led_q))
        else $error("flicker did not toggle on tick");
    gap_dark_a: assert property (
        st_q == SEQ_GAP_A || st_q == SEQ_GAP_B |-> !led_q)
        else $error("led lit during a pause");
    group_count_a: assert property (
        run && st_q == SEQ_DIG_A && count_a != 6'h00 |-> n_q < count_a)
        else $error("more pulses than the code");
    tail_restart_a: assert property (
        tail_done_s |=> st_q == SEQ_FLICK && led_q)
        else $error("sequence did not restart with flicker");
    digit_gap_a: assert property (
        run && tick && st_q == SEQ_DIG_A && win_end && grp_done |=> st_q == SEQ_GAP_B)
        else $error("no pause between digits");
endmodule

// >>> hw/sled_top.sv
/*
 * Status LED block: I/O indicator, network indicator and five-LED signal
 * quality bar, set by software over an Avalon-MM slave with waitrequest.
 * Assumes a 50 MHz mclk, synchronous active-low rst_n, LEDs driven high-on.
 */
// Our own choices: the register addresses and the Avalon-MM interface to the registers.
`include "sled_map.svh"

module sled_top #(
    parameter int TICK_CYCLES = `SLED_TICK_CYCLES
) (
    input  wire logic                mclk,
    input  wire logic                rst_n,
    input  wire logic [3:0]          avs_address,
    input  wire logic                avs_read,
    input  wire logic                avs_write,
    input  wire logic [31:0]         avs_writedata,
    input  wire logic [3:0]          avs_byteenable,
    output logic [31:0]              avs_readdata,
    output logic                     avs_waitrequest,
    output sled_pkg::sled_rg_s       io_led_q,
    output sled_pkg::sled_rg_s       network_indicator_q,
    output sled_pkg::sled_bar_t      quality_bar_q
);
    import sled_pkg::*;

    localparam logic [31:0] IO_RST  = `SLED_IO_CTRL_RST;
    localparam logic [31:0] NET_RST = `SLED_NET_CTRL_RST;

    function automatic sled_rg_s rg(input logic r, input logic g);
        return '{red: r, green: g};
    endfunction

    logic [31:0] io_ctrl_q, net_ctrl_q;
    logic [31:0] rdata_q;
    logic        wait_q;
    logic [21:0] tdiv_q;
    logic        tick_q;
    logic [2:0]  rdiv_q;
    logic        recov_q;
    logic        fast_q;
    logic        io_seq_led, io_seq_busy;
    logic        net_seq_led, net_seq_busy;
    sled_rg_s    io_d, net_d;
    sled_bar_t   bar_d;

    ////////////////////////////////////////////////////////////////////////////
    // avalon slave: one wait cycle, then a one-cycle answer
    wire logic        req     = avs_read | avs_write;
    wire logic        wr_ok   = avs_write & ~wait_q;
    wire logic        sel_io  = avs_address == `SLED_IO_CTRL_OFS;
    wire logic        sel_net = avs_address == `SLED_NET_CTRL_OFS;
    wire logic        sel_st  = avs_address == `SLED_STATUS_OFS;
    wire logic [31:0] status_w = {14'h0000, net_seq_busy, io_seq_busy,
                                  2'h0, quality_bar_q, network_indicator_q, io_led_q};
    wire logic [31:0] rd_mux = sel_io  ? io_ctrl_q  :
                               sel_net ? net_ctrl_q :
                               sel_st  ? status_w   : 32'h0000_0000;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0000_0000;
        end else begin
            wait_q  <= ~(req & wait_q);
            if (req & wait_q)
                rdata_q <= rd_mux;
        end
    end

    assign avs_waitrequest = wait_q;
    assign avs_readdata    = rdata_q;

    for (genvar b = 0; b < 4; b++) begin : g_lane
        always_ff @(posedge mclk) begin
            if (!rst_n) begin
                io_ctrl_q[8*b +: 8]  <= IO_RST[8*b +: 8];
                net_ctrl_q[8*b +: 8] <= NET_RST[8*b +: 8];
            end else if (wr_ok && avs_byteenable[b]) begin
                if (sel_io)
                    io_ctrl_q[8*b +: 8] <= avs_writedata[8*b +: 8];
                if (sel_net)
                    net_ctrl_q[8*b +: 8] <= avs_writedata[8*b +: 8];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // field decode
    wire logic       lib_ok   = io_ctrl_q[`SLED_IO_LIB];
    wire logic       startup  = io_ctrl_q[`SLED_IO_STARTUP];
    wire logic       hw_fault = io_ctrl_q[`SLED_IO_HW_FAULT];
    wire logic       recov    = io_ctrl_q[`SLED_IO_RECOV];
    wire logic       bus_err  = io_ctrl_q[`SLED_IO_BUS_ERR];
    wire logic [5:0] err_code = {2'h0, io_ctrl_q[`SLED_IO_CODE_LSB +: 4]};
    wire logic [5:0] err_arg  = io_ctrl_q[`SLED_IO_ARG_LSB +: 6];
    wire logic [1:0] net_type = net_ctrl_q[`SLED_NET_TYPE_LSB +: 2];
    wire logic [2:0] nfault   = net_ctrl_q[`SLED_NET_FAULT_LSB +: 3];
    wire logic [2:0] level    = net_ctrl_q[`SLED_NET_LEVEL_LSB +: 3];

    // unknown fault codes 6 and 7 fall back to the network type view
    wire logic net_run = nfault != `SLED_NF_NONE && nfault <= `SLED_NF_MODEM_TMO;
    wire logic [5:0] net_dig_a = (nfault <= `SLED_NF_SIM_LOCKED) ? 6'h01 : 6'h02;
    wire logic [5:0] net_dig_b =
        (nfault == `SLED_NF_SIM_ABSENT) ? 6'h01 :
        (nfault == `SLED_NF_SIM_LOCKED) ? 6'h02 :
        (nfault == `SLED_NF_MODEM_GONE) ? 6'h01 :
        (nfault == `SLED_NF_MODEM_INIT) ? 6'h02 : 6'h03;

    // the sequence only runs while it is the shown condition, so it
    // restarts from the flicker each time the bus error takes the led
    wire logic io_run = lib_ok & ~hw_fault & bus_err;

    ////////////////////////////////////////////////////////////////////////////
    // time base: 50 ms tick, 2 Hz and flicker-rate square waves
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            tdiv_q <= 22'h000000;
            tick_q <= 1'b0;
        end else begin
            tick_q <= tdiv_q == 22'(TICK_CYCLES - 1);
            tdiv_q <= (tdiv_q == 22'(TICK_CYCLES - 1)) ? 22'h000000 : tdiv_q + 22'h000001;
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdiv_q  <= 3'h0;
            recov_q <= 1'b0;
            fast_q  <= 1'b0;
        end else if (tick_q) begin
            fast_q <= ~fast_q;
            rdiv_q <= (rdiv_q == 3'(`SLED_RECOV_HALF - 1)) ? 3'h0 : rdiv_q + 3'h1;
            if (rdiv_q == 3'(`SLED_RECOV_HALF - 1))
                recov_q <= ~recov_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    sled_pulse_seq u_io_seq (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .tick     (tick_q),
        .run      (io_run),
        .flick_en (1'b1),
        .count_a  (err_code),
        .count_b  (err_arg),
        .tail_gap (6'(`SLED_GAP_TICKS)),
        .led_q    (io_seq_led),
        .busy_q   (io_seq_busy)
    );

    sled_pulse_seq u_net_seq (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .tick     (tick_q),
        .run      (net_run),
        .flick_en (1'b0),
        .count_a  (net_dig_a),
        .count_b  (net_dig_b),
        .tail_gap (6'(`SLED_NET_TAIL)),
        .led_q    (net_seq_led),
        .busy_q   (net_seq_busy)
    );

    ////////////////////////////////////////////////////////////////////////////
    // io indicator priority chain
    assign io_d = hw_fault ? rg(1'b1, 1'b0) :
                  !lib_ok  ? rg(1'b0, 1'b0) :
                  bus_err  ? rg(io_seq_led, 1'b0) :
                  recov    ? rg(recov_q, 1'b0) :
                  startup  ? rg(fast_q, fast_q) :
                             rg(1'b0, 1'b1);

    assign net_d = net_run                ? rg(net_seq_led, 1'b0) :
                   net_type == `SLED_NT_3G ? rg(1'b0, 1'b1) :
                   net_type == `SLED_NT_2G ? rg(1'b1, 1'b1) :
                                             rg(1'b1, 1'b0);

    for (genvar i = 0; i < 5; i++) begin : g_bar
        assign bar_d[i].green  = level >= 3'(i + 2);
        assign bar_d[i].yellow = (i == 0) && (level == 3'h1);
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            io_led_q            <= '0;
            network_indicator_q <= '0;
            quality_bar_q       <= '0;
        end else begin
            io_led_q            <= io_d;
            network_indicator_q <= net_d;
            quality_bar_q       <= bar_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    normal_green_a: assert property (
        lib_ok && !hw_fault && !bus_err && !recov && !startup
        |=> io_led_q.green && !io_led_q.red)
        else $error("io led not green in normal state");
    startup_orange_a: assert property (
        lib_ok && startup && !hw_fault && !bus_err && !recov
        |=> io_led_q.red == io_led_q.green && io_led_q.red == $past(fast_q))
        else $error("startup flash not orange");
    hw_red_a: assert property (
        hw_fault |=> io_led_q.red && !io_led_q.green)
        else $error("hardware fault not steady red");
    recov_rate_a: assert property (
        tick_q && rdiv_q == 3'(`SLED_RECOV_HALF - 1) |=> recov_q != $past(recov_q))
        else $error("recoverable blink off rate");
    recov_red_a: assert property (
        lib_ok && recov && !hw_fault && !bus_err
        |=> io_led_q.red == $past(recov_q) && !io_led_q.green)
        else $error("recoverable error not red blink");
    bus_seq_a: assert property (
        io_run |=> io_led_q.red == $past(io_seq_led) && !io_led_q.green)
        else $error("bus error not shown as sequence");
    lib_dark_a: assert property (
        !lib_ok && !hw_fault |=> io_led_q == '0)
        else $error("io led lit without library");
    // the edge that ends reset still shows the cleared led
    net_type_a: assert property (
        rst_n && !net_run
        |=> network_indicator_q.green == ($past(net_type) inside {`SLED_NT_2G, `SLED_NT_3G})
            && network_indicator_q.red == ($past(net_type) != `SLED_NT_3G))
        else $error("network type colour wrong");
    sim_code_a: assert property (
        nfault == `SLED_NF_SIM_LOCKED |-> net_dig_a == 6'h01 && net_dig_b == 6'h02)
        else $error("sim locked code not 1-2");
    modem_code_a: assert property (
        nfault == `SLED_NF_MODEM_GONE |-> net_dig_a == 6'h02 && net_dig_b == 6'h01)
        else $error("modem absent code not 2-1");
    reset_code_a: assert property (
        nfault == `SLED_NF_MODEM_TMO |-> net_dig_a == 6'h02 && net_dig_b == 6'h03)
        else $error("modem timeout code not 2-3");
    bar_level_a: assert property (
        level >= 3'h2 && level <= 3'h6
        |=> $countones({quality_bar_q[4].green, quality_bar_q[3].green,
                        quality_bar_q[2].green, quality_bar_q[1].green,
                        quality_bar_q[0].green}) == 32'($past(level) - 3'h1))
        else $error("bar green count wrong");
    bar_one_a: assert property (
        level == 3'h1 |=> quality_bar_q[0].yellow && !quality_bar_q[0].green)
        else $error("level one not yellow");
    io_prio_a: assert property (
        lib_ok && bus_err && recov && !hw_fault |=> !io_led_q.green
                                                   && io_led_q.red == $past(io_seq_led))
        else $error("bus error lost to lower priority");

    // register slave: one wait cycle, one answer cycle
    wait_one_a: assert property (
        req && avs_waitrequest |=> !avs_waitrequest)
        else $error("request not answered after one wait cycle");
    wait_pulse_a: assert property (
        !avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    read_data_a: assert property (
        avs_read && avs_waitrequest && sel_io |=> avs_readdata == $past(io_ctrl_q))
        else $error("read data not the io control word");
    write_land_a: assert property (
        avs_write && !avs_waitrequest && sel_io && avs_byteenable == 4'hF
        |=> io_ctrl_q == $past(avs_writedata))
        else $error("write did not land on the answer edge");
endmodule

// >>> sim/sled_led_panel.sv
/*
 * front panel model: counts red flashes seen on the io and network leds.
 * assumes registered leds on mclk and a one-cycle clr pulse from the bench.
 */
module sled_led_panel (
    input  wire logic               mclk,
    input  wire logic               clr,
    input  wire sled_pkg::sled_rg_s io_led,
    input  wire sled_pkg::sled_rg_s net_led,
    output logic [15:0]             io_flashes,
    output logic [15:0]             net_flashes
);
    timeunit 1ns;
    timeprecision 1ns;
    import sled_pkg::*;
    logic io_red_q;
    logic net_red_q;
    // an operator sees a flash as a dark to red change
    always_ff @(posedge mclk) begin
        io_red_q  <= io_led.red;
        net_red_q <= net_led.red;
        if (clr) begin
            io_flashes  <= 16'h0000;
            net_flashes <= 16'h0000;
        end else begin
            io_flashes  <= io_flashes + 16'(io_led.red & ~io_red_q);
            net_flashes <= net_flashes + 16'(net_led.red & ~net_red_q);
        end
    end
endmodule

// >>> sim/status_led_indicator_bench.sv
/*
 * self-checking bench of sled_top with a front panel model.
 * assumes a short tick parameter so every blink pattern fits in a few thousand cycles.
 */
`define CHK(n, e, g) check(n, 32'(e), 32'(g))
module status_led_indicator_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import sled_pkg::*;
    localparam int TK = 4;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        clr = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0000_0000;
    logic [3:0]  avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    sled_rg_s    io_led_q;
    sled_rg_s    network_indicator_q;
    sled_bar_t   quality_bar_q;
    logic [15:0] io_flashes;
    logic [15:0] net_flashes;
    logic [31:0] seed = 32'h0000_A414;
    logic [31:0] q;
    logic [31:0] r;
    int          error_cnt = 0;
    int          n_compared = 0;
    always #10 mclk = ~mclk;
    sled_top #(.TICK_CYCLES(TK)) dut (.mclk(mclk), .rst_n(rst_n), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .io_led_q(io_led_q),
        .network_indicator_q(network_indicator_q), .quality_bar_q(quality_bar_q));
    sled_led_panel panel (.mclk(mclk), .clr(clr), .io_led(io_led_q),
        .net_led(network_indicator_q), .io_flashes(io_flashes), .net_flashes(net_flashes));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    function automatic logic [9:0] bar_exp(int lvl);
        logic [9:0] b;
        b = 10'h000;
        for (int i = 0; i < 5; i++) begin
            if (lvl == 1 && i == 0) b[1:0] = 2'b10;
            if (lvl >= 2 && i < lvl - 1) b[2*i +: 2] = 2'b01;
        end
        return b;
    endfunction
    task automatic check(input string n, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (e !== g) begin
            error_cnt++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge mclk);
    endtask
    // entered just after a rising edge; request held until waitrequest is seen low
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= ~wr;
        do begin
            @(posedge mclk);
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
        @(posedge mclk);
    endtask
    // clear the panel counts before the write so the first flash is not missed
    task automatic meas(input logic [3:0] a, input logic [31:0] d, input int cyc);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        bus(1'b1, a, d, q);
        wt(cyc);
    endtask
    task automatic end_of_test();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #1000000;
        error_cnt++;
        end_of_test();
    end
    initial begin
        int a;
        int b;
        wt(8);
        rst_n <= 1'b1;
        wt(2);
        `CHK("io led reset", 2'b00, io_led_q);
        `CHK("net led none", 2'b10, network_indicator_q);
        `CHK("bar reset", 10'h000, quality_bar_q);
        bus(1'b0, 4'h0, 32'h0, q);
        `CHK("io ctrl reset", 32'h0, q);
        bus(1'b1, 4'hC, 32'hFFFF_FFFF, q);
        bus(1'b0, 4'hC, 32'h0, q);
        `CHK("unmapped read", 32'h0, q);
        repeat (4) begin
            r = rnd();
            bus(1'b1, 4'h0, r, q);
            bus(1'b0, 4'h0, 32'h0, q);
            `CHK("io ctrl readback", r, q);
        end
        avs_byteenable <= 4'h1;
        bus(1'b1, 4'h0, 32'hFFFF_FFFF, q);
        avs_byteenable <= 4'hF;
        bus(1'b0, 4'h0, 32'h0, q);
        `CHK("byte lane write", {r[31:8], 8'hFF}, q);
        bus(1'b1, 4'h0, 32'h0000_0001, q);
        wt(3);
        `CHK("io normal", 2'b01, io_led_q);
        bus(1'b1, 4'h0, 32'h0000_001E, q);
        wt(3);
        `CHK("io fault without library", 2'b10, io_led_q);
        meas(4'h0, 32'h0000_0003, 10 * TK);
        `CHK("startup orange", io_led_q.green, io_led_q.red);
        `CHK("startup flashes", 1, io_flashes >= 4 && io_flashes <= 6);
        bus(1'b1, 4'h0, 32'h0000_001F, q);
        wt(3);
        `CHK("io fault wins", 2'b10, io_led_q);
        meas(4'h0, 32'h0000_000B, 50 * TK);
        `CHK("recoverable 2 Hz", 1, io_flashes >= 4 && io_flashes <= 6);
        // flicker 10, code 3, argument 2, two rounds up to the second tail pause
        meas(4'h0, 32'h0002_031B, 350 * TK);
        `CHK("coded sequence flashes", 30, io_flashes);
        `CHK("coded sequence green off", 1'b0, io_led_q.green);
        for (int c = 1; c <= 5; c++) begin
            a = (c < 3) ? 1 : 2;
            b = (c < 3) ? c : c - 2;
            meas(4'h4, 32'(c) << 4, (a + b + 3) * 20 * TK - 20);
            `CHK("net code flashes", a + b, net_flashes);
            bus(1'b1, 4'h4, 32'h0000_0002, q);
            wt(3);
        end
        for (int t = 0; t < 4; t++) begin
            // type 3 with the unused fault code 6 falls back to red
            bus(1'b1, 4'h4, (t == 3) ? 32'h0000_0063 : 32'(t), q);
            wt(3);
            a = (t == 1) ? 3 : (t == 2) ? 1 : 2;
            `CHK("net type", a, network_indicator_q);
        end
        for (int i = 0; i < 12; i++) begin
            a = (i < 8) ? i : int'(rnd() % 7);
            bus(1'b1, 4'h4, 32'(a) << 8, q);
            wt(3);
            `CHK("quality bar", bar_exp(a), quality_bar_q);
            // io sequence still busy, network none shows red
            bus(1'b0, 4'h8, 32'h0, q);
            `CHK("status", {14'h0000, 1'b0, 1'b1, 2'h0, bar_exp(a), 2'b10}, q[31:2]);
        end
        end_of_test();
    end
endmodule
